/* hw/isd_pkg.sv */
// Package for the speed-detect configuration bank: offsets, field positions, reset values, lookup tables.
// Assumes a word-wide register access port (address, write strobe, data) driven by the serial target logic.
// Operation
// - Config word at 0x80, resets to zero
// - Bit 30 enables initial speed detection
// - Bit 29 enables braking outcome
// - Bit 28 enables high-impedance coasting option
// - Bit 27 enables reverse drive handling
// - Bit 26 enables forward resynchronisation
// - Bit 25 enables stationary brake
// - Bits 24-22 select stationary EMF threshold
// - Bit 21 chooses low or high brake
// - Bits 16-13 select brake duration
// - Bits 12-9 select coast duration
// - Bits 8-6 select stationary brake duration
// - Bits 5-3 set minimum resync EMF
// - Code zero uses minimum duty derived threshold
// - Start-up word at 0x82, resets zero
package isd_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ISD_OFS_SPEED_DETECT = 8'h80; // Speed-detect configuration word
	localparam logic [7:0] ISD_OFS_STARTUP_ONE = 8'h82; // First start-up configuration word
	localparam logic [31:0] ISD_RST_SPEED_DETECT = 32'h00000000;
	localparam logic [31:0] ISD_RST_STARTUP_ONE = 32'h00000000;
	localparam logic [31:0] ISD_UNMAPPED_READ = 32'h00000000; // Answer for other offsets

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ISD_BIT_PARITY = 31;
	localparam int ISD_BIT_DETECT_EN = 30;
	localparam int ISD_BIT_BRAKE_EN = 29;
	localparam int ISD_BIT_COAST_EN = 28;
	localparam int ISD_BIT_REVERSE_EN = 27;
	localparam int ISD_BIT_RESYNC_EN = 26;
	localparam int ISD_BIT_STATIONARY_BRAKE_ENABLE = 25;
	localparam int ISD_LSB_STAT_THR = 22;
	localparam int ISD_BIT_BRK_SELECT = 21;
	localparam int ISD_LSB_BRAKE_DURATION = 13;
	localparam int ISD_LSB_COAST_TIME = 9;
	localparam int ISD_LSB_STAT_BRAKE_DURATION = 6;
	localparam int ISD_LSB_RESYNC_MIN = 3;
	localparam logic [2:0] ISD_RESYNC_FROM_DUTY = 3'h0; // Code meaning derive from minimum duty

	// ----------------------------------------
	// Decoded configuration carrier
	// ----------------------------------------
	typedef struct packed {
		logic parity_flag;
		logic speed_detect_enable;
		logic brake_enable;
		logic coast_option_enable;
		logic reverse_drive_enable;
		logic resync_enable;
		logic stationary_brake_enable;
		logic [2:0] stationary_emf_threshold;
		logic brake_switch_select; // 0 low side, 1 high side
		logic [3:0] brake_duration;
		logic [3:0] coast_duration;
		logic [2:0] stationary_brake_duration;
		logic [2:0] resync_min_code;
	} isd_cfg_t;

	// Scaled values handed to the detection logic
	typedef struct packed {
		logic [6:0] stat_thr_mv;
		logic [13:0] brake_ms;
		logic [13:0] coast_ms;
		logic [9:0] stat_brake_ms;
		logic [10:0] resync_min_mv;
		logic resync_use_duty;
		logic brake_low_side;
		logic brake_high_side;
	} isd_val_t;

	// Sixteen-step table shared by brake and coast durations, in ms
	localparam logic [13:0] ISD_DUR_MS [16] = '{14'h000A, 14'h0032, 14'h0064, 14'h00C8, 14'h012C, 14'h0190,
		14'h01F4, 14'h02EE, 14'h03E8, 14'h07D0, 14'h0BB8, 14'h0FA0, 14'h1388, 14'h1D4C, 14'h2710, 14'h3A98};
	// Stationary EMF threshold in mV
	localparam logic [6:0] ISD_STAT_THR_MV [8] = '{7'h05, 7'h0A, 7'h0F, 7'h14, 7'h19, 7'h1E, 7'h32, 7'h64};
	// Stationary brake time in ms
	localparam logic [9:0] ISD_STAT_BRK_MS [8] = '{10'h001, 10'h00A, 10'h019, 10'h032, 10'h064, 10'h0FA,
		10'h1F4, 10'h3E8};
	// Minimum resync EMF in mV; code zero is unused here
	localparam logic [10:0] ISD_RESYNC_MV [8] = '{11'h000, 11'h12C, 11'h190, 11'h1F4, 11'h258, 11'h320,
		11'h3E8, 11'h4E2};

endpackage : isd_pkg

/* hw/isd_word_store.sv */
// Two-word configuration store; read data come out of a register.
// Assumes one access per cycle from the owning bank.
`timescale 1ns/10ps
module isd_word_store (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic wr_en,
	input wire logic sel,
	input wire logic [31:0] wr_data,
	input wire logic rd_sel,
	output logic [31:0] rd_data,
	output logic [31:0] word0,
	output logic [31:0] word1
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [31:0] w0;
		logic [31:0] w1;
		logic [31:0] rd;
	} isd_store_t;

	isd_store_t st_q;
	isd_store_t st_d;

	// Next state: writes land whole, reserved bits included
	always_comb begin
		st_d = st_q;
		if (wr_en && !sel) begin
			st_d.w0 = wr_data;
		end
		if (wr_en && sel) begin
			st_d.w1 = wr_data;
		end
		st_d.rd = rd_sel ? st_q.w1 : st_q.w0;
	end

	// Register; both words reset to zero
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			st_q.w0 <= isd_pkg::ISD_RST_SPEED_DETECT;
			st_q.w1 <= isd_pkg::ISD_RST_STARTUP_ONE;
			st_q.rd <= 32'h00000000;
		end else begin
			st_q <= st_d;
		end
	end

	assign rd_data = st_q.rd;
	assign word0 = st_q.w0;
	assign word1 = st_q.w1;

endmodule : isd_word_store

/* hw/speed_detect_config_bank.sv */
// Speed-detect configuration bank: stores the words and decodes the fields for the detection logic.
// Assumes a word access port from the serial target; read data valid one cycle after rd_en.
`timescale 1ns/10ps
module speed_detect_config_bank (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [31:0] reg_wr_data,
	output logic [31:0] reg_rd_data,
	output logic reg_rd_valid,
	output isd_pkg::isd_cfg_t cfg,
	output isd_pkg::isd_val_t val,
	output logic [31:0] startup_config_one
);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	logic hit_sd; // Speed-detect word selected
	logic hit_su; // Start-up word selected
	logic [31:0] store_rd; // Registered store data
	logic [31:0] word_sd;
	logic [31:0] word_su;

	assign hit_sd = hit(reg_addr, isd_pkg::ISD_OFS_SPEED_DETECT);
	assign hit_su = hit(reg_addr, isd_pkg::ISD_OFS_STARTUP_ONE);

	isd_word_store u_store (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.wr_en(reg_wr_en && (hit_sd || hit_su)),
		.sel(hit_su),
		.wr_data(reg_wr_data),
		.rd_sel(hit_su),
		.rd_data(store_rd),
		.word0(word_sd),
		.word1(word_su)
	);

	// ----------------------------------------
	// Read handshake state
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic mapped;
	} isd_bank_t;

	isd_bank_t bk_q;
	isd_bank_t bk_d;

	// Remember whether the pending read hit a real word
	always_comb begin
		bk_d.valid = reg_rd_en;
		bk_d.mapped = hit_sd || hit_su;
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			bk_q <= '0;
		end else begin
			bk_q <= bk_d;
		end
	end

	// Unmapped offsets read as zero so software sees no stale word
	assign reg_rd_data = bk_q.mapped ? store_rd : isd_pkg::ISD_UNMAPPED_READ;
	assign reg_rd_valid = bk_q.valid;
	assign startup_config_one = word_su;

	// ----------------------------------------
	// Field decode
	// ----------------------------------------
	// Reserved bits 20..17 and 2..0 are not looked at
	always_comb begin
		cfg.parity_flag = word_sd[isd_pkg::ISD_BIT_PARITY];
		cfg.speed_detect_enable = word_sd[isd_pkg::ISD_BIT_DETECT_EN];
		cfg.brake_enable = word_sd[isd_pkg::ISD_BIT_BRAKE_EN];
		cfg.coast_option_enable = word_sd[isd_pkg::ISD_BIT_COAST_EN];
		cfg.reverse_drive_enable = word_sd[isd_pkg::ISD_BIT_REVERSE_EN];
		cfg.resync_enable = word_sd[isd_pkg::ISD_BIT_RESYNC_EN];
		cfg.stationary_brake_enable = word_sd[isd_pkg::ISD_BIT_STATIONARY_BRAKE_ENABLE];
		cfg.stationary_emf_threshold = word_sd[isd_pkg::ISD_LSB_STAT_THR +: 3];
		cfg.brake_switch_select = word_sd[isd_pkg::ISD_BIT_BRK_SELECT];
		cfg.brake_duration = word_sd[isd_pkg::ISD_LSB_BRAKE_DURATION +: 4];
		cfg.coast_duration = word_sd[isd_pkg::ISD_LSB_COAST_TIME +: 4];
		cfg.stationary_brake_duration = word_sd[isd_pkg::ISD_LSB_STAT_BRAKE_DURATION +: 3];
		cfg.resync_min_code = word_sd[isd_pkg::ISD_LSB_RESYNC_MIN +: 3];
	end

	// Scaled values; enables gate only the brake side outputs, the scaled values follow the codes
	always_comb begin
		val.stat_thr_mv = isd_pkg::ISD_STAT_THR_MV[cfg.stationary_emf_threshold];
		val.brake_ms = isd_pkg::ISD_DUR_MS[cfg.brake_duration];
		val.coast_ms = isd_pkg::ISD_DUR_MS[cfg.coast_duration];
		val.stat_brake_ms = isd_pkg::ISD_STAT_BRK_MS[cfg.stationary_brake_duration];
		val.resync_min_mv = isd_pkg::ISD_RESYNC_MV[cfg.resync_min_code];
		val.resync_use_duty = (cfg.resync_min_code == isd_pkg::ISD_RESYNC_FROM_DUTY);
		// Brake pattern only asserted when some brake path is enabled
		val.brake_low_side = (cfg.brake_enable || cfg.stationary_brake_enable) && !cfg.brake_switch_select;
		val.brake_high_side = (cfg.brake_enable || cfg.stationary_brake_enable) && cfg.brake_switch_select;
	end

endmodule : speed_detect_config_bank

/* test/isd_bank_properties.sv */
// Port checker for the speed-detect configuration bank.
// Assumes a bind from the bench top; one clock, sync active-low reset.
`timescale 1ns/10ps
module isd_bank_properties (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [31:0] reg_wr_data,
	input wire logic [31:0] reg_rd_data,
	input wire logic reg_rd_valid,
	input wire isd_pkg::isd_cfg_t cfg,
	input wire isd_pkg::isd_val_t val,
	input wire logic [31:0] startup_config_one
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// Write aimed at the speed-detect word
	wire wr_cfg = reg_wr_en && reg_addr == isd_pkg::ISD_OFS_SPEED_DETECT;
	// Write aimed at the start-up word
	wire wr_su = reg_wr_en && reg_addr == isd_pkg::ISD_OFS_STARTUP_ONE;
	a_read_valid_next: assert property (reg_rd_en |=> reg_rd_valid)
		else $error("read valid missing");
	a_no_stray_valid: assert property (!reg_rd_en |=> !reg_rd_valid)
		else $error("read valid without request");
	a_cfg_hold: assert property (!wr_cfg |=> $stable(cfg))
		else $error("config changed without write");
	a_enables_wr: assert property (wr_cfg |=> {cfg.speed_detect_enable, cfg.brake_enable,
		cfg.coast_option_enable, cfg.reverse_drive_enable, cfg.resync_enable, cfg.stationary_brake_enable}
		== $past(reg_wr_data[30:25])) else $error("enable bits wrong");
	a_fields_wr: assert property (wr_cfg |=> {cfg.stationary_emf_threshold, cfg.brake_switch_select,
		cfg.brake_duration, cfg.coast_duration, cfg.stationary_brake_duration, cfg.resync_min_code}
		== {$past(reg_wr_data[24:21]), $past(reg_wr_data[16:3])}) else $error("field codes wrong");
	a_parity_wr: assert property (wr_cfg |=> cfg.parity_flag == $past(reg_wr_data[31]))
		else $error("parity flag wrong");
	a_startup_wr: assert property (wr_su |=> startup_config_one == $past(reg_wr_data))
		else $error("start-up word wrong");
	a_duty_code: assert property (val.resync_use_duty == (cfg.resync_min_code == 3'h0))
		else $error("duty fallback wrong");
	a_brake_side: assert property (val.brake_high_side |-> cfg.brake_switch_select)
		else $error("high side brake with low mode");
	a_brake_low: assert property (val.brake_low_side == (!cfg.brake_switch_select
		&& (cfg.brake_enable || cfg.stationary_brake_enable))) else $error("low side brake pattern wrong");
endmodule : isd_bank_properties

/* test/isd_host_model.sv */
// Host model: word accesses as the serial target hands them over.
// Assumes requests are taken on the edge where a strobe is high.
`timescale 1ns/10ps
module isd_host_model (
	input wire logic ref_clk,
	output logic [7:0] reg_addr,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [31:0] reg_wr_data,
	input wire logic [31:0] reg_rd_data,
	input wire logic reg_rd_valid
);
	// Idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_wr_data = 32'h0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr_en <= 1'b1;
		@(posedge ref_clk);
		reg_wr_en <= 1'b0;
		reg_wr_data <= ~d; // Stale data must not look valid
	endtask : wr
	// Bounded wait; valid stands one cycle only
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
		int i;
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge ref_clk);
		reg_rd_en <= 1'b0;
		#1;
		for (i = 0; i < 4 && reg_rd_valid !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		ok = reg_rd_valid === 1'b1;
		d = reg_rd_data;
	endtask : rd
endmodule : isd_host_model

/* test/speed_detect_config_bank_test.sv */
// Bench top: register sequences through the host model.
// Assumes 25 MHz ref_clk and sync active-low reset.
`timescale 1ns/10ps
module speed_detect_config_bank_test;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr;
	logic reg_wr_en, reg_rd_en, reg_rd_valid, ok;
	logic [31:0] reg_wr_data, reg_rd_data, startup_config_one;
	isd_pkg::isd_cfg_t cfg;
	isd_pkg::isd_val_t val;
	int error_cnt = 0;
	int comparisons = 0;
	always #20 ref_clk = ~ref_clk;
	isd_host_model host_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid));
	speed_detect_config_bank dut_u (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
		.cfg(cfg), .val(val), .startup_config_one(startup_config_one));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("comparisons=%0d mismatches=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	// Read with timeout; a lost answer ends the run
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		host_u.rd(a, d, ok);
		if (ok !== 1'b1) begin
			error_cnt++;
			test_done();
		end
		chk(d, exp);
	endtask : rchk
	initial begin
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		rchk(8'h80, 32'h0);
		rchk(8'h82, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 32; i++) begin
			host_u.wr(8'h80, 32'h1 << i);
			rchk(8'h80, 32'h1 << i);
		end
		$display("test bit walk done");
		host_u.wr(8'h80, 32'hFFFFFFFF);
		#1;
		chk({val.brake_ms, val.coast_ms, 4'h0}, {14'h3A98, 14'h3A98, 4'h0});
		chk({val.stat_brake_ms, val.resync_min_mv, val.stat_thr_mv}, {10'h3E8, 11'h4E2, 7'h64});
		host_u.wr(8'h80, 32'h2180F080);
		#1;
		chk({val.brake_ms, val.coast_ms, 4'h0}, {14'h02EE, 14'h03E8, 4'h0});
		chk({val.stat_brake_ms, val.stat_thr_mv, 15'h0}, {10'h019, 7'h32, 15'h0});
		chk({29'h0, val.resync_use_duty, val.brake_low_side, val.brake_high_side}, 32'h6);
		$display("test decode done");
		host_u.wr(8'h84, 32'hFFFFFFFF);
		rchk(8'h84, 32'h0);
		rchk(8'h80, 32'h2180F080);
		host_u.wr(8'h82, 32'hA55A5AA5);
		rchk(8'h82, 32'hA55A5AA5);
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		rchk(8'h82, 32'h0);
		rchk(8'h80, 32'h0);
		$display("test map and reset done");
		test_done();
	end
endmodule : speed_detect_config_bank_test
bind speed_detect_config_bank isd_bank_properties prop_u (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
	.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
	.reg_rd_valid(reg_rd_valid), .cfg(cfg), .val(val), .startup_config_one(startup_config_one));
